// ---- rtl/event_timer.sv ----
// 16-bit up-counter with overflow flag, compare-trigger reset and buffered wide access
// assumes an apb4 master on ref_clk and compare-unit signals on the same clock
`timescale 1ns/1ps
`default_nettype none
module event_timer
    import timer_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic extClockPin,
    input wire logic crystalClockPin,
    input wire logic [3:0] compareMode,
    input wire logic compareTrigger,
    input wire logic adcEnabled,
    input wire logic sysclkFromCrystal,
    input wire logic sleepActive,
    output logic adcStart,
    output logic irqRequest,
    output logic irqHighPriority,
    output logic crystalOscOn,
    output logic crystalLowPowerOn
);
    timer_control_t ctrl_r;
    logic [15:0] count_r;
    logic [7:0] highBuf_r, config_r;
    logic [2:0] presc_r;
    logic flag_r, enable_r, priority_r;
    logic [31:0] prdata_r;
    logic pready_r, pslverr_r, adcStart_r, irqRequest_r, lowPower_r;
    logic extRise, xtalRise;

    pin_sync u_ext_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .pin(extClockPin),
        .rise(extRise)
    );
    pin_sync u_xtal_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .pin(crystalClockPin),
        .rise(xtalRise)
    );

    logic setupRd, accessWr, hit, lowWr, highWr, countWr, flagWr;
    assign setupRd = psel & ~penable & ~pwrite;
    assign accessWr = psel & penable & pready_r & pwrite & pstrb[0];
    assign hit = (paddr == OFS_CTRL) | (paddr == OFS_LOW) | (paddr == OFS_HIGH)
        | (paddr == OFS_FLAGS) | (paddr == OFS_ENABLES) | (paddr == OFS_PRIORITY)
        | (paddr == OFS_CONFIG);
    assign lowWr = accessWr & (paddr == OFS_LOW);
    assign highWr = accessWr & (paddr == OFS_HIGH);
    assign countWr = lowWr | (highWr & ~ctrl_r.wideAccessEnable);
    assign flagWr = accessWr & (paddr == OFS_FLAGS);

    // count source and prescaler
    logic srcEdge, countEvt, tick, trigReset, overflow;
    logic [2:0] prescLimit;
    assign srcEdge = ctrl_r.clockSourceSelect
        ? (ctrl_r.crystalOscEnable ? xtalRise : extRise) : 1'b1;
    assign countEvt = ctrl_r.counterRun & srcEdge;
    assign prescLimit = {&ctrl_r.prescaleSelect, ctrl_r.prescaleSelect[1],
        |ctrl_r.prescaleSelect};
    assign tick = countEvt & (presc_r == prescLimit);
    // unsynchronised external counting cannot honour the trigger reset reliably, so it is dropped
    assign trigReset = (compareMode == COMPARE_MODE_TRIGGER) & compareTrigger
        & ~(ctrl_r.clockSourceSelect & ctrl_r.extClockSyncDisable);
    assign overflow = tick & (count_r == COUNT_MAX) & ~countWr & ~trigReset;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            presc_r <= 3'h0;
        end else if (lowWr) begin
            presc_r <= 3'h0;
        end else if (countEvt) begin
            presc_r <= tick ? 3'h0 : presc_r + 3'h1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            count_r <= COUNT_RESET;
        end else if (lowWr) begin
            if (ctrl_r.wideAccessEnable) begin
                count_r <= {highBuf_r, pwdata[7:0]};
            end else begin
                count_r[7:0] <= pwdata[7:0];
            end
        end else if (highWr & ~ctrl_r.wideAccessEnable) begin
            count_r[15:8] <= pwdata[7:0];
        end else if (trigReset) begin
            count_r <= COUNT_RESET;
        end else if (tick) begin
            count_r <= count_r + 16'h0001;
        end
    end

    // snapshot is taken in the setup cycle so the read data and the buffer match exactly
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            highBuf_r <= 8'h00;
        end else if (highWr & ctrl_r.wideAccessEnable) begin
            highBuf_r <= pwdata[7:0];
        end else if (setupRd & (paddr == OFS_LOW) & ctrl_r.wideAccessEnable) begin
            highBuf_r <= count_r[15:8];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            flag_r <= FLAGS_RESET[OVF_BIT];
        end else begin
            flag_r <= overflow | (flagWr ? pwdata[OVF_BIT] : flag_r);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ctrl_r <= timer_control_t'(CTRL_RESET);
            enable_r <= ENABLES_RESET[OVF_BIT];
            priority_r <= PRIORITY_RESET[OVF_BIT];
            config_r <= CONFIG_RESET;
        end else if (accessWr) begin
            if (paddr == OFS_CTRL) begin
                ctrl_r <= timer_control_t'(pwdata[7:0]);
            end
            if (paddr == OFS_ENABLES) begin
                enable_r <= pwdata[OVF_BIT];
            end
            if (paddr == OFS_PRIORITY) begin
                priority_r <= pwdata[OVF_BIT];
            end
            if (paddr == OFS_CONFIG) begin
                config_r <= pwdata[7:0];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            adcStart_r <= 1'b0;
            irqRequest_r <= 1'b0;
            lowPower_r <= 1'b0;
        end else begin
            adcStart_r <= trigReset & adcEnabled;
            irqRequest_r <= flag_r & enable_r;
            lowPower_r <= sleepActive & ~config_r[LOW_POWER_BIT];
        end
    end

    // apb: zero-wait data phase, answer registered in the setup cycle
    logic [7:0] rdByte;
    always_comb begin
        rdByte = 8'h00;
        case (paddr)
            OFS_CTRL: rdByte = {ctrl_r.wideAccessEnable, sysclkFromCrystal, ctrl_r[5:0]};
            OFS_LOW: rdByte = count_r[7:0];
            OFS_HIGH: rdByte = ctrl_r.wideAccessEnable ? highBuf_r : count_r[15:8];
            OFS_FLAGS: rdByte = {7'h00, flag_r};
            OFS_ENABLES: rdByte = {7'h00, enable_r};
            OFS_PRIORITY: rdByte = {7'h00, priority_r};
            OFS_CONFIG: rdByte = config_r;
            default: rdByte = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0;
        end else begin
            pready_r <= psel & ~penable;
            if (psel & ~penable) begin
                pslverr_r <= ~hit;
                prdata_r <= pwrite ? 32'h0 : {24'h0, rdByte};
            end
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign adcStart = adcStart_r;
    assign irqRequest = irqRequest_r;
    assign irqHighPriority = priority_r;
    assign crystalOscOn = ctrl_r.crystalOscEnable;
    assign crystalLowPowerOn = lowPower_r;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    property p_wrap;
        overflow |=> (count_r == COUNT_RESET) && flag_r;
    endproperty
    a_wrap: assert property (p_wrap) else $error("wrap did not clear count and set flag");
    property p_irq;
        (flag_r && enable_r) |=> irqRequest_r ##1 (irqRequest_r == $past(flag_r & enable_r));
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt request not following flag");
    property p_trig;
        trigReset && !countWr |=> count_r == COUNT_RESET;
    endproperty
    a_trig: assert property (p_trig) else $error("trigger did not clear counter");
    property p_adc;
        trigReset && adcEnabled |=> adcStart_r ##1 !adcStart_r || $past(trigReset);
    endproperty
    a_adc: assert property (p_adc) else $error("conversion start missing");
    property p_trig_noflag;
        trigReset && !flag_r && !flagWr |=> !flag_r;
    endproperty
    a_trig_noflag: assert property (p_trig_noflag) else $error("trigger set flag");
    property p_wr_wins;
        lowWr && trigReset |=> count_r[7:0] == $past(pwdata[7:0]);
    endproperty
    a_wr_wins: assert property (p_wr_wins) else $error("trigger beat write");
    property p_snap;
        setupRd && paddr == OFS_LOW && ctrl_r.wideAccessEnable && !accessWr
            |=> highBuf_r == $past(count_r[15:8]);
    endproperty
    a_snap: assert property (p_snap) else $error("high byte not snapshotted");
    property p_wide_wr;
        lowWr && ctrl_r.wideAccessEnable |=> count_r == {$past(highBuf_r), $past(pwdata[7:0])};
    endproperty
    a_wide_wr: assert property (p_wide_wr) else $error("wide write not atomic");
    property p_hidden;
        highWr && ctrl_r.wideAccessEnable && !trigReset && !tick |=> $stable(count_r);
    endproperty
    a_hidden: assert property (p_hidden) else $error("live high byte written");
    property p_presc;
        lowWr |=> presc_r == 3'h0;
    endproperty
    a_presc: assert property (p_presc) else $error("prescaler not cleared");
    property p_stop;
        !ctrl_r.counterRun && !countWr && !trigReset |=> $stable(count_r);
    endproperty
    a_stop: assert property (p_stop) else $error("counter moved while stopped");
    property p_sticky;
        flag_r && !flagWr |=> flag_r;
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag dropped");
    property p_lowpow;
        sleepActive && !config_r[LOW_POWER_BIT] |=> crystalLowPowerOn;
    endproperty
    a_lowpow: assert property (p_lowpow) else $error("low power not entered");
    property p_rollover;
        tick && count_r == COUNT_MAX && !countWr && !trigReset
            |=> flag_r && count_r == COUNT_RESET;
    endproperty
    a_rollover: assert property (p_rollover) else $error("rollover did not set flag");
    // unsynchronised counting gives up the trigger reset, so the count must hold
    property p_async_drop;
        ctrl_r.clockSourceSelect && ctrl_r.extClockSyncDisable && compareTrigger
            && compareMode == COMPARE_MODE_TRIGGER && !countWr && !tick |=> $stable(count_r);
    endproperty
    a_async_drop: assert property (p_async_drop) else $error("trigger reset in async mode");

    property p_cov_ovf;
        overflow;
    endproperty
    c_cov_ovf: cover property (p_cov_ovf);
    property p_cov_trig;
        trigReset && adcEnabled;
    endproperty
    c_cov_trig: cover property (p_cov_trig);
    property p_cov_wide;
        lowWr && ctrl_r.wideAccessEnable;
    endproperty
    c_cov_wide: cover property (p_cov_wide);
    property p_cov_snap;
        setupRd && paddr == OFS_LOW && ctrl_r.wideAccessEnable;
    endproperty
    c_cov_snap: cover property (p_cov_snap);
    property p_cov_async;
        compareTrigger && ctrl_r.clockSourceSelect && ctrl_r.extClockSyncDisable;
    endproperty
    c_cov_async: cover property (p_cov_async);
endmodule : event_timer
`default_nettype wire

// ---- rtl/timer_pkg.sv ----
// package for the 16-bit event-reset timer: register map, control fields, reset values
// assumes a 32-bit apb slave with byte offsets on one word each
package timer_pkg;
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_LOW = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_HIGH = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_FLAGS = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_ENABLES = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_PRIORITY = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_CONFIG = 8'h18;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] CONFIG_RESET = 8'h20;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] ENABLES_RESET = 8'h00;
    localparam logic [7:0] PRIORITY_RESET = 8'hff;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hffff;
    localparam int OVF_BIT = 0;
    localparam int LOW_POWER_BIT = 5;
    localparam logic [3:0] COMPARE_MODE_TRIGGER = 4'hb;
    typedef struct packed {
        logic wideAccessEnable;
        logic sysclkFromCrystalStatus;
        logic [1:0] prescaleSelect;
        logic crystalOscEnable;
        logic extClockSyncDisable;
        logic clockSourceSelect;
        logic counterRun;
    } timer_control_t;
endpackage : timer_pkg

// ---- rtl/pin_sync.sv ----
// three-flop input synchroniser with agreement filter and rising-edge pulse
// assumes pin is asynchronous to ref_clk
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic pin,
    output logic rise
);
    logic ff1_r, ff2_r, ff3_r, stable_r;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ff1_r <= 1'b0;
            ff2_r <= 1'b0;
            ff3_r <= 1'b0;
        end else begin
            ff1_r <= pin;
            ff2_r <= ff1_r;
            ff3_r <= ff2_r;
        end
    end
    // a change counts only once stages two and three agree
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            stable_r <= 1'b0;
        end else if (ff2_r == ff3_r) begin
            stable_r <= ff3_r;
        end
    end
    assign rise = (ff2_r == ff3_r) & ff3_r & ~stable_r;
endmodule : pin_sync
`default_nettype wire

// ---- tb/compare_unit_model.sv ----
// compare-unit stand-in: mode field and special event pulses
// assumes the timer runs on the same ref_clk
`timescale 1ns/1ps
`default_nettype none
module compare_unit_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [3:0] modeSel,
    input wire logic [15:0] period,
    input wire logic armed,
    input wire logic fireNow,
    output logic [3:0] compareMode,
    output logic compareTrigger
);
    logic [15:0] cnt_r;
    assign compareMode = modeSel;
    always_ff @(posedge ref_clk) begin
        if (rst || !armed || cnt_r == period) cnt_r <= 16'h0000;
        else cnt_r <= cnt_r + 16'h0001;
    end
    // a stray pulse is sent only when the bench asks for one
    always_ff @(posedge ref_clk) begin
        compareTrigger <= !rst && (fireNow || (armed && cnt_r == period));
    end
endmodule : compare_unit_model
`default_nettype wire

// ---- tb/tb_event_timer.sv ----
// testbench for the event timer: apb master, compare-unit model, pin stimulus
// assumes an apb slave that raises pready at some rising edge before the cycle limit
`timescale 1ns/1ps
`default_nettype none
module tb_event_timer;
    import timer_pkg::*;
    typedef struct packed {logic [7:0] a; logic [7:0] d; logic e;} row_t;
    logic ref_clk, rst, psel, penable, pwrite, pready, pslverr, extClockPin, xtalPin, xtalStatus;
    logic [7:0] paddr, rdv;
    logic [31:0] pwdata, prdata;
    logic [3:0] modeSel, compareMode;
    logic [15:0] period;
    logic armed, fireNow, compareTrigger, adcEnabled, sleepActive, erv;
    logic adcStart, irqRequest, irqHighPriority, crystalLowPowerOn, crystalOscOn;
    int err_count, cmp_count, adcCount, cycles, n;
    row_t rows [8] = '{'{OFS_CTRL, 8'h00, 1'b0}, '{OFS_LOW, 8'h00, 1'b0},
        '{OFS_HIGH, 8'h00, 1'b0}, '{OFS_FLAGS, 8'h00, 1'b0}, '{OFS_ENABLES, 8'h00, 1'b0},
        '{OFS_CONFIG, 8'h20, 1'b0}, '{OFS_PRIORITY, 8'h01, 1'b0}, '{8'h1c, 8'h00, 1'b1}};
    event_timer DUT (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .extClockPin(extClockPin),
        .crystalClockPin(xtalPin), .compareMode(compareMode), .compareTrigger(compareTrigger),
        .adcEnabled(adcEnabled), .sysclkFromCrystal(xtalStatus), .sleepActive(sleepActive),
        .adcStart(adcStart), .irqRequest(irqRequest), .irqHighPriority(irqHighPriority),
        .crystalOscOn(crystalOscOn), .crystalLowPowerOn(crystalLowPowerOn));
    compare_unit_model cmpUnit (.ref_clk(ref_clk), .rst(rst), .modeSel(modeSel),
        .period(period), .armed(armed), .fireNow(fireNow), .compareMode(compareMode),
        .compareTrigger(compareTrigger));
    always #2.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        if (adcStart === 1'b1) adcCount <= adcCount + 1;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            close_out();
        end
    end
    task automatic close_out();
        $display("Checks %0d errors %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : close_out
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // fire lines the compare pulse up with the edge that completes the transfer
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
        input logic fire);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h000000, d};
        fireNow <= fire;
        @(posedge ref_clk);
        penable <= 1'b1;
        fireNow <= 1'b0;
        @(posedge ref_clk);
        while (pready !== 1'b1) @(posedge ref_clk);
        rdv = prdata[7:0];
        erv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        xfer(1'b1, a, d, 1'b0);
    endtask : wr
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string nm);
        xfer(1'b0, a, 8'h00, 1'b0);
        chk(nm, rdv, exp);
    endtask : rchk
    task automatic tick(input int k);
        repeat (k) @(posedge ref_clk);
    endtask : tick
    initial begin
        ref_clk = 0; rst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
        extClockPin = 0; modeSel = 0; period = 0; armed = 0; fireNow = 0;
        xtalPin = 0; xtalStatus = 0;
        adcEnabled = 0; sleepActive = 0; err_count = 0; cmp_count = 0;
        adcCount = 0; cycles = 0;
        tick(8);
        rst <= 1'b0;
        chk("prio", irqHighPriority, 1'b1);
        foreach (rows[i]) begin
            xfer(1'b0, rows[i].a, 8'h00, 1'b0);
            chk("row data", rdv, rows[i].d);
            chk("row err", erv, rows[i].e);
        end
        wr(OFS_HIGH, 8'hff);
        wr(OFS_LOW, 8'hfa);
        wr(OFS_ENABLES, 8'h01);
        wr(OFS_CTRL, 8'h01);
        tick(12);
        wr(OFS_CTRL, 8'h00);
        rchk(OFS_HIGH, 8'h00, "wrap");
        rchk(OFS_LOW, 8'h09, "wrap low");
        rchk(OFS_FLAGS, 8'h01, "ovf");
        chk("irq", irqRequest, 1'b1);
        wr(OFS_ENABLES, 8'h00);
        tick(2);
        chk("irq mask", irqRequest, 1'b0);
        rchk(OFS_FLAGS, 8'h01, "sticky");
        wr(OFS_FLAGS, 8'h00);
        rchk(OFS_FLAGS, 8'h00, "clear");
        wr(OFS_CTRL, 8'h80);
        wr(OFS_HIGH, 8'h12);
        wr(OFS_LOW, 8'h34);
        wr(OFS_HIGH, 8'h56);
        rchk(OFS_LOW, 8'h34, "wide low");
        rchk(OFS_HIGH, 8'h12, "snap");
        wr(OFS_CTRL, 8'h00);
        rchk(OFS_HIGH, 8'h12, "live");
        adcEnabled <= 1'b1;
        modeSel <= COMPARE_MODE_TRIGGER;
        n = adcCount;
        xfer(1'b1, OFS_ENABLES, 8'h00, 1'b1);
        tick(3);
        chk("adc", adcCount, n + 1);
        rchk(OFS_LOW, 8'h00, "trig");
        rchk(OFS_FLAGS, 8'h00, "noflag");
        xfer(1'b1, OFS_LOW, 8'h55, 1'b1);
        rchk(OFS_LOW, 8'h55, "wins");
        adcEnabled <= 1'b0;
        n = adcCount;
        xfer(1'b1, OFS_ENABLES, 8'h00, 1'b1);
        tick(3);
        chk("no adc", adcCount, n);
        period <= 16'd20;
        armed <= 1'b1;
        wr(OFS_CTRL, 8'h01);
        tick(30);
        repeat (4) begin
            xfer(1'b0, OFS_LOW, 8'h00, 1'b0);
            chk("period", rdv <= 8'd22, 1'b1);
            tick(7);
        end
        modeSel <= 4'ha;
        tick(40);
        xfer(1'b0, OFS_LOW, 8'h00, 1'b0);
        chk("mode", rdv > 8'd22, 1'b1);
        armed <= 1'b0;
        for (int p = 0; p < 4; p++) begin
            wr(OFS_CTRL, 8'h00);
            wr(OFS_LOW, 8'h00);
            wr(OFS_CTRL, {2'b00, p[1:0], 4'h1});
            tick(40);
            wr(OFS_CTRL, 8'h00);
            xfer(1'b0, OFS_LOW, 8'h00, 1'b0);
            n = 43 >> p;
            chk("scale", rdv + 2 >= n && rdv <= n + 2, 1'b1);
        end
        wr(OFS_LOW, 8'h00);
        wr(OFS_CTRL, 8'h03);
        repeat (5) begin
            extClockPin <= 1'b1;
            tick(6);
            extClockPin <= 1'b0;
            tick(6);
        end
        rchk(OFS_LOW, 8'h05, "ext");
        wr(OFS_CTRL, 8'h07);
        modeSel <= COMPARE_MODE_TRIGGER;
        xfer(1'b1, OFS_ENABLES, 8'h00, 1'b1);
        rchk(OFS_LOW, 8'h05, "async");
        wr(OFS_CTRL, 8'h00);
        wr(OFS_HIGH, 8'hff);
        wr(OFS_LOW, 8'h00);
        wr(OFS_ENABLES, 8'h01);
        xtalStatus <= 1'b1;
        wr(OFS_CTRL, 8'h0f);
        repeat (256) begin
            xtalPin <= 1'b1;
            tick(4);
            xtalPin <= 1'b0;
            tick(4);
        end
        chk("rtc irq", irqRequest, 1'b1);
        chk("osc on", crystalOscOn, 1'b1);
        wr(OFS_HIGH, 8'h80);
        wr(OFS_FLAGS, 8'h00);
        rchk(OFS_HIGH, 8'h80, "rtc msb");
        rchk(OFS_LOW, 8'h00, "rtc low");
        rchk(OFS_CTRL, 8'h4f, "status");
        sleepActive <= 1'b1;
        wr(OFS_CONFIG, 8'h00);
        tick(2);
        chk("lp on", crystalLowPowerOn, 1'b1);
        rst <= 1'b1;
        tick(2);
        rst <= 1'b0;
        tick(2);
        chk("lp rst", crystalLowPowerOn, 1'b0);
        rchk(OFS_CONFIG, 8'h20, "cfg rst");
        rchk(OFS_LOW, 8'h00, "cnt rst");
        rchk(OFS_CTRL, 8'h40, "ctrl rst");
        chk("osc rst", crystalOscOn, 1'b0);
        close_out();
    end
endmodule : tb_event_timer
`default_nettype wire
